/* rtl/emb_ctrl_pkg.sv */
// constants, field layouts and carrier types for the external memory bus controller
// Operation
// - release bit clear keeps bus owning pins
// - release bit set frees pins except accesses
// - release bit resets to zero, bus enabled
// - on-chip-only mode ignores bus-control writes
// - wait field adds zero to three cycles
// - word mode drives latch word, high strobe
// - byte-select mode copies byte, high strobe plus enable
// - byte-write mode copies byte, high or low strobe
// - write mode ignored with eight-bit data
// - bus-control shares address with timer period
// - data width bit selects sixteen or eight
// - address field picks width or on-chip mode
// - unused high address lines stay plain I/O
// - low sixteen lines (twelve in 12-bit mode) carry address then data
// - eight control pins in fixed order
// - width settings fixed, not software writable
// - unused register bits read zero, ignore writes
// - wait field only with wait enable set
// - idle owned pins: tri-state, strobes high
package emb_ctrl_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [11:0] OFS_BUS_CTRL   = 12'h000;  // bus control or timer period
  localparam logic [11:0] OFS_WDT_CTRL   = 12'h004;  // watchdog control (shared select)
  localparam logic [11:0] OFS_STATUS     = 12'h008;  // read-only status
  localparam int unsigned OFS_W          = 12;       // decoded address bits

  // bus control field layout
  localparam int unsigned BIT_RELEASE    = 7;
  localparam int unsigned BIT_WAIT_HI    = 5;
  localparam int unsigned BIT_WAIT_LO    = 4;
  localparam int unsigned BIT_WM_HI      = 1;
  localparam int unsigned BIT_WM_LO      = 0;
  localparam logic [7:0]  BUS_CTRL_WMASK = 8'hb3;    // writable bits 7,5,4,1,0
  localparam logic [7:0]  BUS_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TIMER_PER_RST  = 8'hff;
  localparam int unsigned BIT_SHARED_SEL = 0;        // in watchdog control
  localparam logic [7:0]  WDT_CTRL_WMASK = 8'h01;

  // address width / program memory mode codes
  localparam logic [1:0]  AW_20  = 2'b00;
  localparam logic [1:0]  AW_16  = 2'b01;
  localparam logic [1:0]  AW_12  = 2'b10;
  localparam logic [1:0]  AW_MCU = 2'b11;
  localparam logic [19:0] MASK_20 = 20'hf_ffff;
  localparam logic [19:0] MASK_16 = 20'h0_ffff;
  localparam logic [19:0] MASK_12 = 20'h0_0fff;

  // control pin positions on the control pin port
  localparam int unsigned CTL_ALE  = 0;
  localparam int unsigned CTL_OE_N = 1;
  localparam int unsigned CTL_WRL_N = 2;
  localparam int unsigned CTL_WRH_N = 3;
  localparam int unsigned CTL_BA0  = 4;
  localparam int unsigned CTL_CE_N = 5;
  localparam int unsigned CTL_LB_N = 6;
  localparam int unsigned CTL_UB_N = 7;
  localparam logic [7:0]  CTL_IDLE = 8'hee;          // strobes high, ale and ba0 low

  // timing
  localparam int unsigned TCY_CLKS    = 4;           // reference clocks per instruction cycle
  localparam int unsigned STROBE_CLKS = 3;           // covers the two-flop input sampler

  typedef struct packed {
    logic        write;                              // 1 = table write
    logic [20:0] addr;                               // table pointer
    logic [7:0]  latch;                              // table latch byte
  } tbl_req_t;

  typedef struct packed {
    logic [15:0] ad_out;                             // muxed address/data lines
    logic [15:0] ad_oe;
    logic [3:0]  a_hi_out;                           // upper address lines
    logic [3:0]  a_hi_oe;
    logic [7:0]  ctl_out;                            // control pin port
    logic [7:0]  ctl_oe;
  } pin_bundle_t;

  typedef enum logic [2:0] {ST_IDLE, ST_GRAB, ST_ADDR, ST_STROBE, ST_WAIT, ST_DONE} bus_state_t;

endpackage

/* rtl/emb_ctrl.sv */
// external memory bus controller: ahb-lite registers, table access sequencer and pin muxing
`timescale 1ns/1ps
module emb_ctrl
  import emb_ctrl_pkg::*;
#(
  parameter int unsigned TCY_DIV = TCY_CLKS           // reference clocks per instruction cycle
)(
  input  wire logic        i_ref_clk,                // 25 mhz core clock
  input  wire logic        i_rst_n,                  // synchronous reset, active low
  input  wire logic        i_hsel,                   // ahb slave select
  input  wire logic [31:0] i_haddr,                  // ahb address
  input  wire logic [1:0]  i_htrans,                 // ahb transfer type
  input  wire logic        i_hwrite,                 // ahb write
  input  wire logic [2:0]  i_hsize,                  // ahb size (word only)
  input  wire logic [31:0] i_hwdata,                 // ahb write data
  input  wire logic        i_hready,                 // ahb bus ready
  output logic      [31:0] o_hrdata,                 // ahb read data
  output logic             o_hreadyout,              // ahb slave ready
  output logic             o_hresp,                  // ahb response, always okay
  input  wire logic        i_data_width_cfg,         // 1 = 16-bit data
  input  wire logic [1:0]  i_addr_width_mode_cfg,    // address width / memory mode
  input  wire logic        i_wait_enable_cfg,        // wait states enabled
  input  wire logic        i_exec_external,          // core executing from external memory
  input  wire logic        i_tbl_valid,              // table operation request pulse
  input  wire tbl_req_t    i_tbl_req,                // table operation
  output logic             o_tbl_done,               // table operation finished pulse
  output logic      [15:0] o_tbl_rdata,              // table read data
  output logic             o_tbl_busy,               // sequencer busy
  output logic      [7:0]  o_timer_period,           // timer period register value
  input  wire pin_bundle_t i_gpio,                   // port drive when pins are released
  input  wire logic [15:0] i_ad_in,                  // muxed line levels from the pins
  output pin_bundle_t      o_pins                    // pin drive and enables
);

  // wait count meaning no wait states left
  localparam logic [1:0] WAIT_NONE = 2'b00;

  // instruction-cycle divider
  logic [7:0]  tcy_cnt_reg;                          // divider count
  logic        tcy_en_reg;                           // one-cycle instruction-cycle pulse

  // configuration captured at reset
  logic        cfg_data16_reg;                       // data width
  logic [1:0]  cfg_aw_reg;                           // address width / mode
  logic        cfg_wait_en_reg;                      // wait states allowed

  // software registers
  logic [7:0]  bus_control_reg;                      // release, wait, write mode
  logic [7:0]  timer_period_reg;                     // shares the bus control offset
  logic [7:0]  watchdog_control_reg;                 // shared select
  logic        release_eff_reg;                      // release bit as applied to the pins

  // ahb data-phase bookkeeping
  logic              dp_wr_reg;                      // write pending in data phase
  logic [OFS_W-1:0]  dp_ofs_reg;                     // its offset

  // sequencer
  bus_state_t  state_reg;                            // bus cycle state
  logic [3:0]  phase_cnt_reg;                        // clocks spent in a phase
  logic [1:0]  wait_cnt_reg;                         // instruction cycles still to wait
  tbl_req_t    req_reg;                              // accepted request
  logic [7:0]  word_low_reg;                         // low byte held for word writes
  logic [15:0] cyc_ad_reg;                           // value for the muxed lines
  logic        cyc_ad_oe_reg;                        // device drives muxed lines
  logic [3:0]  cyc_ahi_reg;                          // value for upper address lines
  logic [7:0]  cyc_ctl_reg;                          // control pin values

  // input sampler for the muxed lines
  logic [15:0] ad_meta_reg;                          // first stage, read only by second
  logic [15:0] ad_sync_reg;                          // safe to read

  logic        ext_mode;                             // external bus exists
  logic        bus_own;                              // bus holds the shared pins
  logic [19:0] line_mask;                            // lines used by this address width
  logic        ap_take;                              // ahb address phase accepted
  logic        sel_timer;                            // shared offset maps to timer period

  // mask of the lines the address width uses
  function automatic logic [19:0] width_mask(input logic [1:0] aw);
    unique case (aw)
      AW_20:   width_mask = MASK_20;
      AW_16:   width_mask = MASK_16;
      AW_12:   width_mask = MASK_12;
      AW_MCU:  width_mask = '0;
    endcase
  endfunction

  // wait states for a wait field: 11 none, 00 three
  function automatic logic [1:0] wait_cycles(input logic en, input logic [1:0] field);
    wait_cycles = en ? ~field : WAIT_NONE;
  endfunction

  assign ext_mode  = (cfg_aw_reg != AW_MCU);
  assign line_mask = width_mask(cfg_aw_reg);
  // released pins are grabbed only for the span of an access
  assign bus_own   = ext_mode && (!release_eff_reg || state_reg != ST_IDLE);
  assign ap_take   = i_hsel && i_htrans[1] && i_hready;
  assign sel_timer = watchdog_control_reg[BIT_SHARED_SEL];

  // free-running instruction-cycle divider
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || tcy_cnt_reg == 8'(TCY_DIV - 1))
    begin
      tcy_cnt_reg <= '0;
      tcy_en_reg  <= i_rst_n;
    end
    else
    begin
      tcy_cnt_reg <= tcy_cnt_reg + 8'd1;
      tcy_en_reg  <= 1'b0;
    end
  end

  // configuration is latched while reset is held and never written afterwards
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      cfg_data16_reg  <= i_data_width_cfg;
      cfg_aw_reg      <= i_addr_width_mode_cfg;
      cfg_wait_en_reg <= i_wait_enable_cfg;
    end
  end

  // ahb address phase: remember writes, load read data so it stands in the data phase
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      dp_wr_reg  <= 1'b0;
      dp_ofs_reg <= '0;
      o_hrdata   <= '0;
    end
    else if (i_hready)
    begin
      dp_wr_reg  <= ap_take && i_hwrite;
      dp_ofs_reg <= i_haddr[OFS_W-1:0];
      if (ap_take && !i_hwrite)
      begin
        unique case (i_haddr[OFS_W-1:0])
          OFS_BUS_CTRL:
            // disabled control register reads as zero in on-chip mode
            o_hrdata <= sel_timer ? {24'h00_0000, timer_period_reg}
                      : ext_mode  ? {24'h00_0000, bus_control_reg & BUS_CTRL_WMASK}
                      : '0;
          OFS_WDT_CTRL: o_hrdata <= {24'h00_0000, watchdog_control_reg};
          OFS_STATUS:   o_hrdata <= {24'h00_0000, o_tbl_busy, bus_own, release_eff_reg,
                                     cfg_wait_en_reg, cfg_data16_reg, ext_mode, cfg_aw_reg};
          default:      o_hrdata <= '0;             // unmapped reads zero
        endcase
      end
    end
  end

  // zero-wait slave, every answer okay
  always_ff @(posedge i_ref_clk)
  begin
    o_hreadyout <= 1'b1;
    o_hresp     <= 1'b0;
  end

  // register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      bus_control_reg      <= BUS_CTRL_RST;
      timer_period_reg     <= TIMER_PER_RST;
      watchdog_control_reg <= '0;
    end
    else if (dp_wr_reg)
    begin
      if (dp_ofs_reg == OFS_BUS_CTRL && sel_timer)
        timer_period_reg <= i_hwdata[7:0];
      else if (dp_ofs_reg == OFS_BUS_CTRL && ext_mode)
        bus_control_reg <= i_hwdata[7:0] & BUS_CTRL_WMASK;
      if (dp_ofs_reg == OFS_WDT_CTRL)
        watchdog_control_reg <= i_hwdata[7:0] & WDT_CTRL_WMASK;
    end
  end

  // setting the release bit from external code waits until execution is internal
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      release_eff_reg <= 1'b0;
    else if (!bus_control_reg[BIT_RELEASE] || !i_exec_external)
      release_eff_reg <= bus_control_reg[BIT_RELEASE];
  end

  // two-flop sampler on the muxed lines
  always_ff @(posedge i_ref_clk)
  begin
    ad_meta_reg <= i_ad_in;
    ad_sync_reg <= ad_meta_reg;
  end

  // table access sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg     <= ST_IDLE;
      phase_cnt_reg <= '0;
      wait_cnt_reg  <= '0;
      req_reg       <= '0;
      word_low_reg  <= '0;
      o_tbl_done    <= 1'b0;
      o_tbl_busy    <= 1'b0;
      o_tbl_rdata   <= '0;
    end
    else
    begin
      o_tbl_done    <= 1'b0;
      phase_cnt_reg <= phase_cnt_reg + 4'd1;
      unique case (state_reg)
        ST_IDLE:
          if (i_tbl_valid && ext_mode)
          begin
            req_reg       <= i_tbl_req;
            phase_cnt_reg <= '0;
            // word mode holds the even byte and writes on the odd one
            if (i_tbl_req.write && cfg_data16_reg && bus_control_reg[BIT_WM_HI]
                && !i_tbl_req.addr[0])
            begin
              word_low_reg <= i_tbl_req.latch;
              o_tbl_done   <= 1'b1;
            end
            else
            begin
              state_reg  <= ST_GRAB;
              o_tbl_busy <= 1'b1;
            end
          end
          else if (i_tbl_valid)
            o_tbl_done <= 1'b1;                      // no bus in on-chip mode
        ST_GRAB:
        begin
          // one clock with pins already owned before ale rises
          state_reg     <= ST_ADDR;
          phase_cnt_reg <= '0;
        end
        ST_ADDR:
        begin
          state_reg     <= ST_STROBE;
          phase_cnt_reg <= '0;
        end
        ST_STROBE:
          if (phase_cnt_reg == 4'(STROBE_CLKS - 1))
          begin
            wait_cnt_reg <= wait_cycles(cfg_wait_en_reg,
                              bus_control_reg[BIT_WAIT_HI:BIT_WAIT_LO]);
            state_reg    <= ST_WAIT;
          end
        ST_WAIT:
          // extra delay follows the executing cycle, counted in instruction cycles
          if (wait_cnt_reg == WAIT_NONE)
            state_reg <= ST_DONE;
          else if (tcy_en_reg)
          begin
            wait_cnt_reg <= wait_cnt_reg - 2'd1;
            o_tbl_rdata  <= ad_sync_reg;             // slow memory: sample late
          end
        ST_DONE:
        begin
          state_reg  <= ST_IDLE;
          o_tbl_rdata <= ad_sync_reg;                // sampler lags two clocks behind the strobe
          o_tbl_done <= 1'b1;
          o_tbl_busy <= 1'b0;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // values the bus wants on its lines in each phase
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      cyc_ad_reg    <= '0;
      cyc_ad_oe_reg <= 1'b0;
      cyc_ahi_reg   <= '0;
      cyc_ctl_reg   <= CTL_IDLE;
    end
    else
    begin
      cyc_ctl_reg   <= CTL_IDLE;
      cyc_ad_oe_reg <= 1'b0;
      unique case (state_reg)
        ST_GRAB:
        begin
          // address first on the low sixteen lines
          cyc_ad_oe_reg              <= 1'b1;
          cyc_ad_reg                 <= cfg_data16_reg ? req_reg.addr[16:1]
                                                       : req_reg.addr[15:0];
          cyc_ahi_reg                <= cfg_data16_reg ? req_reg.addr[20:17]
                                                       : req_reg.addr[19:16];
          cyc_ctl_reg[CTL_ALE]       <= 1'b1;
          cyc_ctl_reg[CTL_CE_N]      <= 1'b0;
          cyc_ctl_reg[CTL_BA0]       <= req_reg.addr[0];
        end
        ST_ADDR, ST_STROBE, ST_WAIT:
        begin
          cyc_ctl_reg[CTL_CE_N] <= 1'b0;
          cyc_ctl_reg[CTL_BA0]  <= req_reg.addr[0];
          if (state_reg != ST_ADDR && !req_reg.write)
            cyc_ctl_reg[CTL_OE_N] <= 1'b0;           // read: memory drives
          else if (state_reg != ST_ADDR)
          begin
            // then data on the same lines
            cyc_ad_oe_reg <= 1'b1;
            if (!cfg_data16_reg)
            begin
              cyc_ad_reg             <= {8'h00, req_reg.latch};
              cyc_ctl_reg[CTL_WRL_N] <= 1'b0;
            end
            else if (bus_control_reg[BIT_WM_HI])
            begin
              cyc_ad_reg             <= {req_reg.latch, word_low_reg};
              cyc_ctl_reg[CTL_WRH_N] <= 1'b0;
            end
            else
            begin
              cyc_ad_reg <= {req_reg.latch, req_reg.latch};
              if (bus_control_reg[BIT_WM_LO])
              begin
                cyc_ctl_reg[CTL_WRH_N] <= 1'b0;
                cyc_ctl_reg[CTL_UB_N]  <= !req_reg.addr[0];
                cyc_ctl_reg[CTL_LB_N]  <= req_reg.addr[0];
              end
              else
              begin
                cyc_ctl_reg[CTL_WRH_N] <= !req_reg.addr[0];
                cyc_ctl_reg[CTL_WRL_N] <= req_reg.addr[0];
              end
            end
          end
        end
        default:
          cyc_ahi_reg <= cyc_ahi_reg;
      endcase
    end
  end

  // pin muxing: owned lines take the bus values, others the port drive
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_pins <= '0;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (bus_own && line_mask[i])
        begin
          o_pins.ad_out[i] <= cyc_ad_reg[i];
          o_pins.ad_oe[i]  <= cyc_ad_oe_reg;
        end
        else
        begin
          o_pins.ad_out[i] <= i_gpio.ad_out[i];
          o_pins.ad_oe[i]  <= i_gpio.ad_oe[i];
        end
      end
      for (int i = 0; i < 4; i++)
      begin
        if (bus_own && line_mask[16 + i])
        begin
          o_pins.a_hi_out[i] <= cyc_ahi_reg[i];
          o_pins.a_hi_oe[i]  <= cyc_ad_oe_reg;
        end
        else
        begin
          o_pins.a_hi_out[i] <= i_gpio.a_hi_out[i];
          o_pins.a_hi_oe[i]  <= i_gpio.a_hi_oe[i];
        end
      end
      if (bus_own)
      begin
        o_pins.ctl_out <= cyc_ctl_reg;
        o_pins.ctl_oe  <= '1;
      end
      else
      begin
        o_pins.ctl_out <= i_gpio.ctl_out;
        o_pins.ctl_oe  <= i_gpio.ctl_oe;
      end
    end
  end

  // timer sees its period one clock after the shared register
  always_ff @(posedge i_ref_clk)
  begin
    o_timer_period <= timer_period_reg;
  end

endmodule

/* bench/emb_ctrl_props.sv */
// concurrent checks on the external memory bus controller ports
`timescale 1ns/1ps
module emb_ctrl_props
  import emb_ctrl_pkg::*;
(
  input  wire logic        i_ref_clk,              // core clock
  input  wire logic        i_rst_n,                // synchronous reset, active low
  input  wire logic [1:0]  i_addr_width_mode_cfg,  // address width / memory mode
  input  wire pin_bundle_t i_gpio,                 // port drive
  input  wire logic        o_hreadyout,            // ahb slave ready
  input  wire logic        o_hresp,                // ahb response
  input  wire logic        o_tbl_done,             // table op finished
  input  wire logic        o_tbl_busy,             // sequencer busy
  input  wire pin_bundle_t o_pins                  // pin drive and enables
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [2:0]  up_reg;  // cycles since reset release, saturating
  pin_bundle_t gq_reg;  // port drive one cycle back, pins are registered
  logic        up;      // past the reset settling cycles
  logic [1:0]  md;      // mode shorthand
  assign up = up_reg >= 3'h3;
  assign md = i_addr_width_mode_cfg;
  // settle counter keeps reset values out of the pin checks
  always_ff @(posedge i_ref_clk)
  begin
    gq_reg <= i_gpio;
    if (!i_rst_n) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  sequence ale_s;
    o_pins.ctl_out[CTL_ALE] && !o_pins.ctl_out[CTL_CE_N] && o_pins.ad_oe[0];
  endsequence
  sequence hold_s;
    !o_pins.ctl_out[CTL_ALE] && !o_pins.ctl_out[CTL_CE_N];
  endsequence
  ready_okay_a: assert property (up |-> o_hreadyout && !o_hresp)
    else $error("slave not ready or response not okay");
  idle_ctl_a: assert property ((up && !o_tbl_busy) [*3] ##0
    (md != AW_MCU && o_pins.ctl_oe == 8'hff) |-> o_pins.ctl_out == CTL_IDLE)
    else $error("idle control pins wrong");
  mcu_port_a: assert property (up && md == AW_MCU |-> o_pins == gq_reg)
    else $error("on-chip mode pins not port driven");
  hi_free_a: assert property ((md == AW_16 || md == AW_12) && up |->
    o_pins.a_hi_out == gq_reg.a_hi_out && o_pins.a_hi_oe == gq_reg.a_hi_oe)
    else $error("unused upper address lines taken");
  ad12_free_a: assert property (up && md == AW_12 |->
    o_pins.ad_out[15:12] == gq_reg.ad_out[15:12] && o_pins.ad_oe[15:12] == gq_reg.ad_oe[15:12])
    else $error("unused muxed lines taken");
  done_pulse_a: assert property (o_tbl_done |=> !o_tbl_done)
    else $error("done longer than one cycle");
  busy_bound_a: assert property ($rose(o_tbl_busy) |-> ##[1:40] o_tbl_done)
    else $error("table op too long");
  ale_seq_a: assert property ($rose(o_pins.ctl_out[CTL_ALE]) && up
    && md != AW_MCU |-> ale_s ##1 hold_s)
    else $error("address phase malformed");
endmodule
bind emb_ctrl emb_ctrl_props i_emb_ctrl_props (.i_ref_clk, .i_rst_n, .i_addr_width_mode_cfg,
  .i_gpio, .o_hreadyout, .o_hresp, .o_tbl_done, .o_tbl_busy, .o_pins);

/* bench/emb_mem_model.sv */
// behavioural external parallel memory on the muxed bus
`timescale 1ns/1ps
module emb_mem_model
  import emb_ctrl_pkg::*;
(
  input  wire logic        i_ref_clk,  // bus clock
  input  wire pin_bundle_t i_pins,     // controller pin drive
  output logic      [15:0] o_ad_in     // levels on the muxed lines
);
  logic [19:0] lat_reg  = '0;  // address caught under latch enable
  logic [15:0] wdat_reg = '0;  // data seen under a write strobe
  logic [3:0]  wstb_reg = '0;  // {ub, lb, wrh, wrl} under that strobe
  logic [15:0] last_reg = '0;  // previous line level
  logic [7:0]  c;              // control pins, undriven ones pulled high
  logic        rd_on;          // memory drives the lines
  assign c = i_pins.ctl_out | ~i_pins.ctl_oe;
  assign rd_on = !c[CTL_OE_N] && !c[CTL_CE_N];
  // released lines flip every cycle so a stale sample cannot pass by luck
  assign o_ad_in = rd_on ? {lat_reg[7:0], ~lat_reg[7:0]} :
                   (i_pins.ad_out & i_pins.ad_oe) | (~last_reg & ~i_pins.ad_oe);
  // latch address, then capture write data and strobes
  always @(posedge i_ref_clk)
  begin
    last_reg <= o_ad_in;
    if (c[CTL_ALE]) lat_reg <= {i_pins.a_hi_out, i_pins.ad_out};
    if (!c[CTL_WRL_N] || !c[CTL_WRH_N])
    begin
      wdat_reg <= i_pins.ad_out;
      wstb_reg <= {c[CTL_UB_N], c[CTL_LB_N], c[CTL_WRH_N], c[CTL_WRL_N]};
    end
  end
endmodule

/* bench/emb_ctrl_tb.sv */
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
module emb_ctrl_tb;
  import emb_ctrl_pkg::*;
  logic        i_ref_clk = 0, i_rst_n = 0, i_hsel = 1, i_hwrite = 0, i_hready;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
  logic [1:0]  i_htrans = 0, i_addr_width_mode_cfg = 0;
  logic [2:0]  i_hsize = 3'h2;
  logic        i_data_width_cfg = 1, i_wait_enable_cfg = 1, i_exec_external = 0;
  logic        i_tbl_valid = 0, o_hreadyout, o_hresp, o_tbl_done, o_tbl_busy;
  logic [15:0] i_ad_in, o_tbl_rdata;
  logic [7:0]  o_timer_period;
  tbl_req_t    i_tbl_req = '0;
  pin_bundle_t o_pins;
  pin_bundle_t i_gpio = '{16'h1234, 16'h00ff, 4'h5, 4'h3, 8'hee, 8'h0f};  // fixed port drive
  int          errors = 0, checks_done = 0, cyc = 0, n, lat[4];
  assign i_hready = o_hreadyout;  // single slave
  always #20 i_ref_clk = ~i_ref_clk;
  emb_ctrl i_emb_ctrl (.i_ref_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_data_width_cfg,
    .i_addr_width_mode_cfg, .i_wait_enable_cfg, .i_exec_external, .i_tbl_valid, .i_tbl_req,
    .o_tbl_done, .o_tbl_rdata, .o_tbl_busy, .o_timer_period, .i_gpio, .i_ad_in, .o_pins);
  emb_mem_model i_emb_mem_model (.i_ref_clk, .i_pins(o_pins), .o_ad_in(i_ad_in));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // config pins are only captured while reset is low
  task rst(input logic dw, input logic [1:0] aw, input logic we);
    i_rst_n <= 0;
    i_data_width_cfg <= dw;
    i_addr_width_mode_cfg <= aw;
    i_wait_enable_cfg <= we;
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1;
  endtask
  // one ahb-lite single word transfer, read data left in rd
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_htrans <= 2'b10;
    i_haddr <= {20'h0_0000, a};
    i_hwrite <= w;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'b00;
    i_hwdata <= d;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  // table op, n counts cycles from accept to done
  task tbl(input logic w, input logic [20:0] a, input logic [7:0] l);
    @(posedge i_ref_clk);
    i_tbl_valid <= 1;
    i_tbl_req <= '{w, a, l};
    @(posedge i_ref_clk);
    i_tbl_valid <= 0;
    n = 0;
    while (o_tbl_done !== 1'b1)
    begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask
  // write latch 0x3c in a write mode, compare {data, strobes} seen by the memory
  task wcase(input logic [1:0] wm, input logic [20:0] a, input logic [19:0] e, m);
    ahb(1, OFS_BUS_CTRL, {30'h0000_0000, wm});
    tbl(1, a, 8'h3c);
    chk({i_emb_mem_model.wdat_reg, i_emb_mem_model.wstb_reg} & m, e);
  endtask
  // hang guard, whole run needs a few hundred cycles
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results;
    end
  end
  initial
  begin
    rst(1, AW_20, 1);
    ahb(0, OFS_BUS_CTRL, 0);
    chk(rd, 32'h0000_0000);
    ahb(1, OFS_STATUS, 0);
    ahb(0, OFS_STATUS, 0);
    chk(rd, 32'h0000_005c);
    ahb(1, OFS_BUS_CTRL, 32'hffff_ffff);
    ahb(0, OFS_BUS_CTRL, 0);
    chk(rd, 32'h0000_00b3);
    repeat (2) @(posedge i_ref_clk);
    chk(o_pins.ad_oe, i_gpio.ad_oe);
    tbl(0, 21'h0_0a55, 8'h00);
    chk(o_tbl_rdata, 16'h2ad5);
    ahb(1, OFS_BUS_CTRL, 32'h0000_0030);
    // release flop, then pin flop: the second update is seen one edge later
    repeat (3) @(posedge i_ref_clk);
    chk(o_pins.ad_oe, 16'h0000);
    chk(o_pins.ctl_out, CTL_IDLE);
    ahb(1, OFS_WDT_CTRL, 32'h0000_0001);
    ahb(1, OFS_BUS_CTRL, 32'h0000_005a);
    ahb(0, OFS_BUS_CTRL, 0);
    chk(rd, 32'h0000_005a);
    chk(o_timer_period, 8'h5a);
    ahb(1, OFS_WDT_CTRL, 0);
    ahb(1, 12'h040, 32'hffff_ffff);
    ahb(0, OFS_BUS_CTRL, 0);
    chk(rd, 32'h0000_0030);
    ahb(0, 12'h040, 0);
    chk(rd, 32'h0000_0000);
    // word address 0x052a comes back as low byte then its inverse
    for (int k = 0; k < 4; k++)
    begin
      ahb(1, OFS_BUS_CTRL, k << 4);
      tbl(0, 21'h0_0a55, 8'h00);
      lat[k] = n;
      chk(o_tbl_rdata, 16'h2ad5);
    end
    chk((lat[0] - lat[3]) inside {[9:15]}, 1);
    for (int k = 2; k < 4; k++)
    begin
      ahb(1, OFS_BUS_CTRL, k);
      tbl(1, 21'h0_0100, 8'h11);
      wcase(k, 21'h0_0101, 20'h3_c111, 20'hf_fff3);
    end
    wcase(1, 21'h0_0101, 20'h3_c3c5, 20'hf_ffff);
    wcase(1, 21'h0_0100, 20'h3_c3c9, 20'hf_ffff);
    wcase(0, 21'h0_0101, 20'h3_c3c1, 20'hf_fff3);
    wcase(0, 21'h0_0100, 20'h3_c3c2, 20'hf_fff3);
    chk(i_emb_mem_model.lat_reg, 20'h0_0080);
    rst(0, AW_16, 1);
    for (int k = 0; k < 3; k++) wcase(k, 21'h0_0101, 20'h0_03c2, 20'h0_0ff3);
    chk(i_emb_mem_model.lat_reg[15:0], 16'h0101);
    rst(0, AW_12, 0);
    tbl(0, 21'h0_0055, 8'h00);
    chk(n, lat[3]);
    rst(1, AW_MCU, 1);
    ahb(1, OFS_BUS_CTRL, 32'h0000_0080);
    ahb(0, OFS_BUS_CTRL, 0);
    chk(rd, 32'h0000_0000);
    ahb(0, OFS_STATUS, 0);
    chk(rd[1:0], AW_MCU);
    tbl(1, 21'h0_0101, 8'h3c);
    results;
  end
endmodule
